// ---- rtl/pew_top.v ----
// Power event routing, power button override and wakeup control
`timescale 1ns/1ns
`include "pew_defs.vh"
module pew_top #(
  parameter OVR_CYCLES = `PEW_OVR_CYCLES,
  parameter CNT_W = 27,
  parameter NPME = 8,
  parameter NSMI = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire button_in_n,
  input wire gpe_event_in,
  input wire alarm_in,
  input wire alarm_missed_in,
  input wire [NPME-1:0] pme_src_in,
  input wire [NSMI-1:0] smi_src_in,
  output reg supply_on_req_n,
  output reg pm_event_out_n,
  output reg pm_event_oe_n,
  output reg legacy_irq_out_n,
  output reg serirq_smi_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word-aligned match of a byte address against a register index
  function addr_hit;
    input [11:0] addr;
    input [7:0] idx;
    begin
      addr_hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
    end
  endfunction

  // Write-one-to-clear with set winning over clear
  function [7:0] w1c;
    input [7:0] cur;
    input [7:0] set;
    input [7:0] clr;
    begin
      w1c = (cur & ~clr) | set;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and edge detection

  localparam SW = 5 + NPME + NSMI;
  wire [SW-1:0] sync_w;
  reg [SW-1:0] sync_d_r;

  pew_sync #(
    .W(SW)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({smi_src_in, pme_src_in, alarm_missed_in, alarm_in, gpe_event_in,
               ~button_in_n, 1'b1}),
    .sync_out(sync_w)
  );

  // Delayed copy for edge detection
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_d_r <= {SW{1'b0}};
    else
      sync_d_r <= sync_w;
  end

  wire [SW-1:0] rise_w = sync_w & ~sync_d_r;
  wire btn_held = sync_w[1];
  wire btn_press = rise_w[1];
  wire gpe_rise = rise_w[2];
  wire alarm_rise = rise_w[3];
  wire missed_rise = rise_w[4];
  wire [NPME-1:0] pme_rise = rise_w[5 +: NPME];
  wire [NSMI-1:0] smi_rise = rise_w[5 + NPME +: NSMI];

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg [7:0] acpi_sts_r;
  reg [7:0] acpi_en_r;
  reg [7:0] smi_sts_r;
  reg [7:0] smi_en1_r;
  reg [7:0] smi_enable_second_r;
  reg [7:0] pme_status_group_r;
  reg [7:0] pme_global_enable_r;
  reg [7:0] pme_ctl_r;
  reg [7:0] acpi_ctl_r;
  reg [7:0] supply_r;
  reg supply_on_r;
  reg [CNT_W-1:0] hold_cnt_r;
  reg hold_done_r;

  wire wr_en = psel && penable && pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire wr_acpi_sts = wr_en && addr_hit(paddr, `PEW_IDX_ACPI_STS);
  wire wr_smi_sts = wr_en && addr_hit(paddr, `PEW_IDX_SMI_STS);
  wire wr_pme_status_group = wr_en && addr_hit(paddr, `PEW_IDX_PME_STATUS_GROUP);
  wire wr_supply = wr_en && addr_hit(paddr, `PEW_IDX_SUPPLY);
  wire software_power_off_wr = wr_supply && wd[`PEW_B_SOFTWARE_POWER_OFF];

  // Routing controls
  wire sci_route_enable = acpi_ctl_r[`PEW_B_SCI];
  wire legacy_route_select = supply_r[`PEW_B_LEGACY];
  wire alarm_remember_enable = supply_r[`PEW_B_ALREM];
  wire smi_output_enable = smi_enable_second_r[`PEW_B_SMI_OUT];
  wire pme_global_enable = pme_ctl_r[`PEW_B_PME_GLB];
  wire all_events_pme_enable = pme_ctl_r[`PEW_B_PME_ALL];
  wire button_override_flag = acpi_sts_r[`PEW_B_OVR];
  wire alarm_en = acpi_en_r[`PEW_B_ALARM];

  ////////////////////////////////////////////////////////////////////////////
  // Power button hold counter

  wire ovr_fire = btn_held && supply_on_r && !hold_done_r &&
                  (hold_cnt_r == OVR_CYCLES[CNT_W-1:0] - 1'b1);

  // Counter restarts on each press and runs only while held with supply on
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_cnt_r <= {CNT_W{1'b0}};
      hold_done_r <= 1'b0;
    end
    else if (btn_press || !btn_held)
    begin
      hold_cnt_r <= {CNT_W{1'b0}};
      hold_done_r <= 1'b0;
    end
    else if (ovr_fire)
      hold_done_r <= 1'b1;
    else if (supply_on_r && !hold_done_r)
      hold_cnt_r <= hold_cnt_r + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flag updates

  reg [7:0] acpi_set;
  reg [7:0] acpi_clr;
  reg rem_wake;
  reg [7:0] smi_set;
  reg [7:0] pme_set;

  // Hardware set terms and the software and override clear terms of the ACPI group
  always @*
  begin
    rem_wake = missed_rise && alarm_remember_enable;
    acpi_set = 8'h00;
    acpi_set[`PEW_B_BTN] = btn_press;
    acpi_set[`PEW_B_GPE] = gpe_rise;
    acpi_set[`PEW_B_ALARM] = (alarm_rise && alarm_en) || rem_wake;
    acpi_set[`PEW_B_OVR] = ovr_fire;
    acpi_clr = wr_acpi_sts ? wd : 8'h00;
    acpi_clr[`PEW_B_BTN] = acpi_clr[`PEW_B_BTN] | ovr_fire;
    // Source edges widened to the register width
    smi_set = 8'h00;
    smi_set[NSMI-1:0] = smi_rise;
    pme_set = 8'h00;
    pme_set[NPME-1:0] = pme_rise;
  end

  // Flags hold until written with one, or for the press flag until the override fires; a set in the same cycle wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acpi_sts_r <= `PEW_RST_REG;
      smi_sts_r <= `PEW_RST_REG;
      pme_status_group_r <= `PEW_RST_REG;
    end
    else
    begin
      acpi_sts_r <= w1c(acpi_sts_r, acpi_set, acpi_clr) & 8'h0f;
      smi_sts_r <= w1c(smi_sts_r, smi_set, wr_smi_sts ? wd : 8'h00);
      pme_status_group_r <= w1c(pme_status_group_r, pme_set, wr_pme_status_group ? wd : 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers written by software

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acpi_en_r <= `PEW_RST_REG;
      smi_en1_r <= `PEW_RST_REG;
      smi_enable_second_r <= `PEW_RST_REG;
      pme_global_enable_r <= `PEW_RST_REG;
      pme_ctl_r <= `PEW_RST_REG;
      acpi_ctl_r <= `PEW_RST_REG;
      supply_r <= `PEW_RST_REG;
    end
    else if (wr_en)
    begin
      if (addr_hit(paddr, `PEW_IDX_ACPI_EN))
        acpi_en_r <= wd & 8'h07;
      else if (addr_hit(paddr, `PEW_IDX_SMI_EN1))
        smi_en1_r <= wd;
      else if (addr_hit(paddr, `PEW_IDX_SMI_ENABLE_SECOND))
        smi_enable_second_r <= wd;
      else if (addr_hit(paddr, `PEW_IDX_PME_GLOBAL_ENABLE))
        pme_global_enable_r <= wd;
      else if (addr_hit(paddr, `PEW_IDX_PME_CTL))
        pme_ctl_r <= wd & 8'h03;
      else if (addr_hit(paddr, `PEW_IDX_ACPI_CTL))
        acpi_ctl_r <= wd;
      else if (wr_supply)
        supply_r <= wd & 8'h06; // Power off bit is a command and reads as zero
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event routing and wakeup

  wire [2:0] acpi_act = acpi_sts_r[2:0] & acpi_en_r[2:0];
  wire acpi_any = |acpi_act;
  wire pme_any = |(pme_status_group_r & pme_global_enable_r);
  wire smi_any = |(smi_sts_r & smi_en1_r);
  wire acpi_wake = acpi_any && !button_override_flag;
  wire pme_wake = all_events_pme_enable && pme_any && !button_override_flag;
  wire pme_req = (sci_route_enable && acpi_any)
               || ((pme_global_enable || all_events_pme_enable) && pme_any)
               || (pme_global_enable && acpi_act[`PEW_B_BTN]);
  wire acpi_smi = !sci_route_enable && !legacy_route_select && smi_output_enable
                  && acpi_any;
  wire smi_req = (smi_output_enable && smi_any) || acpi_smi;

  reg supply_nxt;

  // Turning off wins over any wake in the same cycle
  always @*
  begin
    supply_nxt = supply_on_r;
    if (ovr_fire || software_power_off_wr)
      supply_nxt = 1'b0;
    else if (!supply_on_r && btn_press)
      supply_nxt = 1'b1;
    else if (!supply_on_r && (acpi_wake || pme_wake || rem_wake))
      supply_nxt = 1'b1;
  end

  // Registered outputs, active low except serirq_smi_req
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      supply_on_r <= 1'b0;
      supply_on_req_n <= 1'b1;
      pm_event_out_n <= 1'b1;
      pm_event_oe_n <= 1'b1;
      legacy_irq_out_n <= 1'b1;
      serirq_smi_req <= 1'b0;
    end
    else
    begin
      supply_on_r <= supply_nxt;
      supply_on_req_n <= ~supply_nxt;
      pm_event_out_n <= ~pme_req;
      pm_event_oe_n <= ~pme_req;
      legacy_irq_out_n <= ~smi_req;
      serirq_smi_req <= smi_req && smi_enable_second_r[`PEW_B_SMI_SIRQ];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle

  reg [7:0] rd_val;
  reg rd_hit;

  // Read multiplexer and address decode
  always @*
  begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (addr_hit(paddr, `PEW_IDX_ACPI_STS))
      rd_val = acpi_sts_r;
    else if (addr_hit(paddr, `PEW_IDX_ACPI_EN))
      rd_val = acpi_en_r;
    else if (addr_hit(paddr, `PEW_IDX_SMI_STS))
      rd_val = smi_sts_r;
    else if (addr_hit(paddr, `PEW_IDX_SMI_EN1))
      rd_val = smi_en1_r;
    else if (addr_hit(paddr, `PEW_IDX_SMI_ENABLE_SECOND))
      rd_val = smi_enable_second_r;
    else if (addr_hit(paddr, `PEW_IDX_PME_STATUS_GROUP))
      rd_val = pme_status_group_r;
    else if (addr_hit(paddr, `PEW_IDX_PME_GLOBAL_ENABLE))
      rd_val = pme_global_enable_r;
    else if (addr_hit(paddr, `PEW_IDX_PME_CTL))
      rd_val = pme_ctl_r;
    else if (addr_hit(paddr, `PEW_IDX_ACPI_CTL))
      rd_val = acpi_ctl_r;
    else if (addr_hit(paddr, `PEW_IDX_SUPPLY))
      rd_val = supply_r;
    else
      rd_hit = 1'b0;
  end

  // Bus answer registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (psel && !penable)
      begin
        prdata <= pwrite ? 32'h00000000 : {24'h000000, rd_val};
        pslverr <= !rd_hit;
      end
    end
  end

endmodule // pew_top

// ---- inc/pew_defs.vh ----
// Constants for the power event routing and wakeup block
`ifndef PEW_DEFS_VH
`define PEW_DEFS_VH

// Register indices; the byte address is four times the index
`define PEW_IDX_ACPI_STS 8'h00
`define PEW_IDX_ACPI_EN 8'h02
`define PEW_IDX_SMI_STS 8'h10
`define PEW_IDX_SMI_EN1 8'h16
`define PEW_IDX_SMI_ENABLE_SECOND 8'h17
`define PEW_IDX_PME_STATUS_GROUP 8'h30
`define PEW_IDX_PME_GLOBAL_ENABLE 8'h31
`define PEW_IDX_PME_CTL 8'h32
`define PEW_IDX_ACPI_CTL 8'h60
`define PEW_IDX_SUPPLY 8'hf8

// Status and enable group bit positions
`define PEW_B_BTN 0
`define PEW_B_GPE 1
`define PEW_B_ALARM 2
`define PEW_B_OVR 3

// Second SMI enable register bits
`define PEW_B_SMI_SIRQ 6
`define PEW_B_SMI_OUT 7

// First ACPI control register bit
`define PEW_B_SCI 0

// Supply control register bits
`define PEW_B_SOFTWARE_POWER_OFF 0
`define PEW_B_LEGACY 1
`define PEW_B_ALREM 2

// PME control register bits
`define PEW_B_PME_GLB 0
`define PEW_B_PME_ALL 1

// Reset value of every register
`define PEW_RST_REG 8'h00

// Override hold time and clock rate
`define PEW_OVR_TIME_MS 4000
`define PEW_CLK_HZ 20000000
`define PEW_OVR_CYCLES ((`PEW_CLK_HZ / 1000) * `PEW_OVR_TIME_MS)

`endif

// ---- rtl/pew_sync.v ----
// Two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ns
module pew_sync #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] meta_r;

  // First stage feeds only the second stage
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // pew_sync

// ---- dv/pew_top_asserts.sv ----
// Port-level checks for the power event routing block
`timescale 1ns/1ns
module pew_top_asserts #(
  parameter OVR_CYCLES = 50
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire button_in_n,
  input wire supply_on_req_n,
  input wire pm_event_out_n,
  input wire pm_event_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] hold_r;
  wire mapped = paddr inside {12'h000, 12'h008, 12'h040, 12'h058, 12'h05c,
    12'h0c0, 12'h0c4, 12'h0c8, 12'h180, 12'h3e0};
  //////////////////////////////
  // Counts cycles of button held while main power is on
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      hold_r <= 32'h0;
    else if (!button_in_n && !supply_on_req_n)
      hold_r <= hold_r + 32'h1;
    else
      hold_r <= 32'h0;
  //////////////////////////////
  // Steps of the bus command and of a button press
  sequence s_off_cmd;
    psel && penable && pwrite && paddr == 12'h3e0 && pwdata[0];
  endsequence
  sequence s_press;
    $fell(button_in_n) && supply_on_req_n ##1 !button_in_n [*4];
  endsequence
  //////////////////////////////
  a_ready_zero_wait:
    assert property (psel && penable |-> pready) else $error("pready low in access");
  a_unmapped_err:
    assert property (psel && !penable && !mapped |=> pslverr) else $error("no slave error");
  a_mapped_ok:
    assert property (psel && !penable && mapped |=> !pslverr) else $error("false slave error");
  a_rdata_upper:
    assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read upper bits set");
  a_rdata_hold:
    assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
  a_oe_follows_pin:
    assert property (pm_event_oe_n == pm_event_out_n) else $error("event enable mismatch");
  a_soft_off_drop:
    assert property (s_off_cmd |-> ##[1:2] supply_on_req_n) else $error("supply kept on");
  a_press_wakes:
    assert property (s_press |-> ##[0:3] !supply_on_req_n) else $error("press did not wake");
  a_hold_override:
    assert property (hold_r <= OVR_CYCLES + 8) else $error("override did not fire");
endmodule // pew_top_asserts

bind pew_top pew_top_asserts #(.OVR_CYCLES(OVR_CYCLES)) pew_top_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .button_in_n(button_in_n), .supply_on_req_n(supply_on_req_n),
  .pm_event_out_n(pm_event_out_n), .pm_event_oe_n(pm_event_oe_n));

// ---- dv/pew_far_model.sv ----
// Model of the chipset event line and the switched main supply
`timescale 1ns/1ns
module pew_far_model (
  input wire pclk,
  input wire slow,
  input wire supply_on_req_n,
  input wire pm_event_out_n,
  input wire pm_event_oe_n,
  output wire pme_line,
  output logic vcc_good
);
  int cnt = 0;
  initial vcc_good = 1'b0;
  // Open-drain line with the board pull-up
  assign pme_line = pm_event_oe_n ? 1'b1 : pm_event_out_n;
  // Rail ramps some cycles after the request, drops at once on release
  always @(posedge pclk)
    if (supply_on_req_n)
    begin
      cnt <= 0;
      vcc_good <= 1'b0;
    end
    else if (cnt < (slow ? 40 : 3))
      cnt <= cnt + 1;
    else
      vcc_good <= 1'b1;
endmodule // pew_far_model

// ---- dv/testbench.sv ----
// Self-checking bench for the power event routing block
`timescale 1ns/1ns
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic pready, pslverr, supply_on_req_n, pm_event_out_n, pm_event_oe_n;
  logic legacy_irq_out_n, serirq_smi_req, pme_line, vcc_good;
  logic [2:0] ev = 0; // Press, generic event, alarm
  logic missed = 0; // Alarm passed while standby power was absent
  logic [7:0] pme_src_in = 0, smi_src_in = 0, rv;
  logic [31:0] q[$];
  int errors = 0, checks_done = 0;
  integer seed = 32'h5f3e4884;
  //////////////////////////////
  initial forever #25 pclk = ~pclk;
  pew_top #(.OVR_CYCLES(50)) pew_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .button_in_n(!ev[0]), .gpe_event_in(ev[1]),
    .alarm_in(ev[2]), .alarm_missed_in(missed), .pme_src_in(pme_src_in),
    .smi_src_in(smi_src_in), .supply_on_req_n(supply_on_req_n),
    .pm_event_out_n(pm_event_out_n), .pm_event_oe_n(pm_event_oe_n),
    .legacy_irq_out_n(legacy_irq_out_n), .serirq_smi_req(serirq_smi_req));
  pew_far_model pew_far_model_inst (.pclk(pclk), .slow(slow),
    .supply_on_req_n(supply_on_req_n), .pm_event_out_n(pm_event_out_n),
    .pm_event_oe_n(pm_event_oe_n), .pme_line(pme_line), .vcc_good(vcc_good));
  //////////////////////////////
  task test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      errors++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task fin(input int t);
    $display("test %0d done", t);
  endtask
  // One bus transfer; a read leaves its expected data in the queue
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    if (!w)
      q.push_back({24'h0, d});
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk("pready", 1, pready);
    if (pready !== 1'b1)
      test_done;
    psel <= 0;
    penable <= 0;
  endtask
  // Waits, bounded, for one output to reach a level
  task wo(input int i, input logic v);
    int n;
    logic [4:0] o;
    for (n = 0; n < 200; n++)
    begin
      @(negedge pclk);
      o = {vcc_good, serirq_smi_req, legacy_irq_out_n, pme_line, supply_on_req_n};
      if (o[i] === v)
        break;
    end
    chk($sformatf("out%0d", i), v, o[i]);
    if (o[i] !== v)
      test_done;
  endtask
  task pulse(input logic [2:0] m);
    @(posedge pclk);
    ev <= ev | m;
    cyc(6);
    ev <= ev & ~m;
    cyc(2);
  endtask
  task off;
    apb(1, 12'h3e0, 8'h01);
    wo(0, 1);
  endtask
  //////////////////////////////
  // Read data matched against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      chk("prdata", q.pop_front(), prdata);
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge pclk);
    errors++;
    test_done;
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    wo(0, 1);
    wo(1, 1);
    wo(3, 0);
    apb(0, 12'h3e0, 8'h00);
    apb(0, 12'h004, 8'h00);
    fin(0);
    apb(1, 12'h008, 8'h01);
    apb(1, 12'h0c8, 8'h01);
    pulse(3'b001);
    wo(0, 0);
    wo(1, 0);
    apb(0, 12'h000, 8'h01);
    apb(1, 12'h000, 8'h00);
    apb(0, 12'h000, 8'h01);
    apb(1, 12'h000, 8'h01);
    apb(0, 12'h000, 8'h00);
    wo(1, 1);
    apb(1, 12'h0c8, 8'h00);
    off;
    apb(0, 12'h3e0, 8'h00);
    fin(1);
    slow <= 1;
    apb(1, 12'h008, 8'h04);
    apb(1, 12'h180, 8'h01);
    pulse(3'b100);
    wo(0, 0);
    wo(1, 0);
    wo(4, 1);
    apb(0, 12'h0c0, 8'h00);
    apb(0, 12'h000, 8'h04);
    apb(1, 12'h000, 8'h04);
    wo(1, 1);
    off;
    fin(2);
    apb(1, 12'h180, 8'h00);
    apb(1, 12'h05c, 8'h80);
    apb(1, 12'h008, 8'h02);
    pulse(3'b010);
    wo(2, 0);
    wo(0, 0);
    apb(1, 12'h3e0, 8'h02);
    wo(2, 1);
    apb(1, 12'h3e0, 8'h00);
    wo(2, 0);
    apb(1, 12'h000, 8'h02);
    wo(2, 1);
    off;
    fin(3);
    rv = $random(seed) | 8'h01;
    apb(1, 12'h058, 8'hff);
    apb(1, 12'h05c, 8'hc0);
    smi_src_in <= rv;
    wo(2, 0);
    wo(3, 1);
    cyc(10);
    wo(0, 1);
    apb(0, 12'h040, rv);
    apb(1, 12'h040, rv);
    smi_src_in <= 0;
    wo(2, 1);
    fin(4);
    rv = $random(seed) | 8'h01;
    apb(1, 12'h0c4, 8'hff);
    pme_src_in <= rv;
    cyc(10);
    wo(1, 1);
    apb(0, 12'h0c0, rv);
    apb(1, 12'h0c8, 8'h01);
    wo(1, 0);
    wo(2, 1);
    apb(1, 12'h0c8, 8'h02);
    wo(0, 0);
    wo(1, 0);
    apb(1, 12'h0c0, rv);
    pme_src_in <= 0;
    wo(1, 1);
    apb(1, 12'h0c8, 8'h00);
    off;
    fin(5);
    apb(1, 12'h3e0, 8'h04);
    missed <= 1;
    wo(0, 0);
    apb(0, 12'h000, 8'h04);
    apb(1, 12'h000, 8'h04);
    missed <= 0;
    off;
    fin(6);
    pulse(3'b000);
    ev <= 3'b001;
    wo(0, 0);
    wo(0, 1);
    pulse(3'b000);
    ev <= 3'b000;
    apb(0, 12'h000, 8'h08);
    pulse(3'b010);
    cyc(10);
    wo(0, 1);
    pulse(3'b001);
    wo(0, 0);
    fin(7);
    test_done;
  end
endmodule // testbench
